// file: icrs_pkg.sv
`default_nettype none

package icrs_pkg;

    // Core clock and link clock periods in nanoseconds.
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned LINK_PERIOD_NS = 48;

    // Power-on reset duration, and its length in core cycles.
    localparam int unsigned POR_TIME_NS = 500000;
    localparam int unsigned POR_CYC     = POR_TIME_NS / CLK_PERIOD_NS;

    // SCK toggles once per link cycle, so half an SCK period is one link period.
    localparam int unsigned SLEEP_MIN_NS  = LINK_PERIOD_NS;
    localparam int unsigned SLEEP_MIN_CYC =
        (SLEEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Frame layout: one done flag followed by the result bits.
    localparam int unsigned FRAME_BITS = 32;
    localparam int unsigned RES_W      = FRAME_BITS - 1;
    localparam logic [5:0]  LAST_EDGE  = 6'h20;

    // Core-side sequencing states.
    typedef enum logic [2:0] {
        CORE_POR,
        CORE_CONV,
        CORE_SLEEP,
        CORE_FRAME,
        CORE_EXT
    } icrs_core_state_t;

    // Link-side pin states.
    typedef enum logic [1:0] {
        LINK_OFF,
        LINK_CONV,
        LINK_SLEEP,
        LINK_FRAME
    } icrs_link_state_t;

    // Levels passed from the core domain to the link domain.
    typedef struct packed {
        logic run;
        logic sleep;
        logic start_tgl;
    } icrs_cross_t;

endpackage : icrs_pkg

`default_nettype wire

// file: icrs_streamer.sv
`default_nettype none

module icrs_streamer #(
    parameter int unsigned POR_CYCLES = icrs_pkg::POR_CYC
) (
    // Core clock and reset.
    input  wire logic                     CLK_I,
    input  wire logic                     RST_N_I,
    // Link clock that times the serial clock.
    input  wire logic                     LINK_CLK_I,
    // Conversion engine handshake, core domain.
    input  wire logic                     CONV_DONE_I,
    input  wire logic [icrs_pkg::RES_W-1:0] RESULT_I,
    output logic                          CONV_START_O,
    // Serial clock pin and its weak pull-up.
    input  wire logic                     SCK_I,
    output logic                          SCK_O,
    output logic                          SCK_OE_O,
    output logic                          SCK_PU_O,
    // Serial data pin.
    output logic                          SDO_O,
    output logic                          SDO_OE_O,
    // Chip select threshold comparator, pull-up and current sink.
    input  wire logic                     CS_LOW_I,
    output logic                          CS_PU_O,
    output logic                          CS_SINK_O,
    // Selected clock mode.
    output logic                          MODE_EXT_O
);

    // ---------------- Core domain ----------------

    icrs_pkg::icrs_core_state_t   core_q;
    logic [31:0]                  por_cnt_q;
    logic [7:0]                   slp_cnt_q;
    logic [icrs_pkg::RES_W-1:0]   result_q;
    logic                         start_tgl_q;
    logic                         conv_start_q;
    logic                         sck_m_q;
    logic                         sck_s_q;
    logic                         cs_m_q;
    logic                         cs_s_q;
    logic                         done_m_q;
    logic                         done_s_q;
    logic                         done_seen_q;
    logic                         done_tgl_q;
    logic                         frame_end;

    // Clock pin level, read only when power-on reset ends; only the second stage is read.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sck_m_q <= 1'b0;
            sck_s_q <= 1'b0;
        end else begin
            sck_m_q <= SCK_I;
            sck_s_q <= sck_m_q;
        end
    end

    // Threshold comparator; a slow analog edge could otherwise split the frame start.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cs_m_q <= 1'b0;
            cs_s_q <= 1'b0;
        end else begin
            cs_m_q <= CS_LOW_I;
            cs_s_q <= cs_m_q;
        end
    end

    // Frame-end toggle coming back from the link domain.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            done_m_q <= 1'b0;
            done_s_q <= 1'b0;
        end else begin
            done_m_q <= done_tgl_q;
            done_s_q <= done_m_q;
        end
    end

    // A toggle from the link marks the end of each frame.
    assign frame_end = done_s_q != done_seen_q;

    // Power-on, conversion, sleep and frame sequencing.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            core_q       <= icrs_pkg::CORE_POR;
            por_cnt_q    <= 32'h0;
            slp_cnt_q    <= 8'h0;
            start_tgl_q  <= 1'b0;
            conv_start_q <= 1'b0;
            done_seen_q  <= 1'b0;
        end else begin
            conv_start_q <= 1'b0;
            case (core_q)
                icrs_pkg::CORE_POR: begin
                    por_cnt_q <= por_cnt_q + 32'h1;
                    if (por_cnt_q == 32'(POR_CYCLES - 1)) begin
                        if (sck_s_q) begin
                            core_q       <= icrs_pkg::CORE_CONV;
                            conv_start_q <= 1'b1;
                        end else begin
                            core_q <= icrs_pkg::CORE_EXT;
                        end
                    end
                end
                icrs_pkg::CORE_CONV: begin
                    if (CONV_DONE_I) begin
                        core_q    <= icrs_pkg::CORE_SLEEP;
                        slp_cnt_q <= 8'h0;
                    end
                end
                icrs_pkg::CORE_SLEEP: begin
                    if (slp_cnt_q != 8'(icrs_pkg::SLEEP_MIN_CYC)) begin
                        slp_cnt_q <= slp_cnt_q + 8'h1;
                    end else if (cs_s_q) begin
                        // Tied-low chip select starts at once after the minimum sleep.
                        core_q      <= icrs_pkg::CORE_FRAME;
                        start_tgl_q <= ~start_tgl_q;
                    end
                end
                icrs_pkg::CORE_FRAME: begin
                    // Stays here until the link reports the last rise of the frame.
                    if (frame_end) begin
                        done_seen_q  <= done_s_q;
                        core_q       <= icrs_pkg::CORE_CONV;
                        conv_start_q <= 1'b1;
                    end
                end
                default: begin
                    core_q <= icrs_pkg::CORE_EXT;
                end
            endcase
        end
    end

    // The finished result is held static until the next completion while converting.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            result_q <= '0;
        end else if (core_q == icrs_pkg::CORE_CONV && CONV_DONE_I) begin
            result_q <= RESULT_I;
        end
    end

    // Clock pull-up: on through power-on reset and every sleep, so a floating clock
    // pin reads high whenever the clock source is chosen.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            SCK_PU_O <= 1'b1;
        end else begin
            SCK_PU_O <= core_q == icrs_pkg::CORE_POR ||
                        core_q == icrs_pkg::CORE_SLEEP;
        end
    end

    // Select pull-up holds the timing capacitor high while converting.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CS_PU_O <= 1'b0;
        end else begin
            CS_PU_O <= core_q == icrs_pkg::CORE_CONV;
        end
    end

    // The sink runs only in sleep, so it never fights the pull-up.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CS_SINK_O <= 1'b0;
        end else begin
            CS_SINK_O <= core_q == icrs_pkg::CORE_SLEEP;
        end
    end

    // External mode flag; the pins then stay released for good.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            MODE_EXT_O <= 1'b0;
        end else begin
            MODE_EXT_O <= core_q == icrs_pkg::CORE_EXT;
        end
    end

    assign CONV_START_O = conv_start_q;

    // ---------------- Link domain ----------------

    icrs_pkg::icrs_cross_t        cross_q;
    icrs_pkg::icrs_cross_t        cross_m_q;
    icrs_pkg::icrs_cross_t        cross_s_q;
    icrs_pkg::icrs_link_state_t   link_q;
    logic                         lrst_m_q;
    logic                         lrst_n_q;
    logic                         taken_q;
    logic [icrs_pkg::RES_W-1:0]   shift_q;
    logic [5:0]                   edge_cnt_q;
    logic                         sck_q;
    logic                         sdo_q;
    logic                         oe_q;

    // Core state as registered levels. A decode straight from the state could glitch
    // into the other domain; sleep and start_tgl can change together, but each is read as its own level, so bitwise sync is safe.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cross_q <= '0;
        end else begin
            cross_q.run       <= core_q != icrs_pkg::CORE_POR &&
                                 core_q != icrs_pkg::CORE_EXT;
            cross_q.sleep     <= core_q == icrs_pkg::CORE_SLEEP;
            cross_q.start_tgl <= start_tgl_q;
        end
    end

    // Reset release is resynchronised to the link clock.
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            lrst_m_q <= 1'b0;
            lrst_n_q <= 1'b0;
        end else begin
            lrst_m_q <= 1'b1;
            lrst_n_q <= lrst_m_q;
        end
    end

    // Two-stage synchroniser for the crossing levels.
    always_ff @(posedge LINK_CLK_I or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            cross_m_q <= '0;
            cross_s_q <= '0;
        end else begin
            cross_m_q <= cross_q;
            cross_s_q <= cross_m_q;
        end
    end

    // Pin sequencing; SCK toggles once per link cycle inside a frame.
    always_ff @(posedge LINK_CLK_I or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            link_q     <= icrs_pkg::LINK_OFF;
            taken_q    <= 1'b0;
            shift_q    <= '0;
            edge_cnt_q <= 6'h0;
            sck_q      <= 1'b0;
            sdo_q      <= 1'b0;
            oe_q       <= 1'b0;
            done_tgl_q <= 1'b0;
        end else begin
            case (link_q)
                icrs_pkg::LINK_OFF: begin
                    // External mode never leaves here, so the pins stay released.
                    if (cross_s_q.run) begin
                        link_q <= icrs_pkg::LINK_CONV;
                        oe_q   <= 1'b1;
                        sck_q  <= 1'b1;
                        sdo_q  <= 1'b1;
                    end
                end
                icrs_pkg::LINK_CONV: begin
                    // A pending start counts too, in case the short sleep level was missed.
                    if (cross_s_q.sleep || cross_s_q.start_tgl != taken_q) begin
                        link_q <= icrs_pkg::LINK_SLEEP;
                        sck_q  <= 1'b0;
                        sdo_q  <= 1'b0;
                    end
                end
                icrs_pkg::LINK_SLEEP: begin
                    // Pending start is compared, not edge-detected, so none is lost.
                    // The held result only changes on a completion, so it is still here.
                    if (cross_s_q.start_tgl != taken_q) begin
                        taken_q    <= cross_s_q.start_tgl;
                        link_q     <= icrs_pkg::LINK_FRAME;
                        shift_q    <= result_q;
                        edge_cnt_q <= 6'h0;
                    end
                end
                default: begin
                    if (sck_q && edge_cnt_q == icrs_pkg::LAST_EDGE) begin
                        // One cycle after the last rise, SDO rises with SCK held high.
                        link_q     <= icrs_pkg::LINK_CONV;
                        sdo_q      <= 1'b1;
                        done_tgl_q <= ~done_tgl_q;
                    end else begin
                        sck_q <= ~sck_q;
                        if (!sck_q) begin
                            edge_cnt_q <= edge_cnt_q + 6'h1;
                        end else begin
                            sdo_q   <= shift_q[icrs_pkg::RES_W-1];
                            shift_q <= {shift_q[icrs_pkg::RES_W-2:0], 1'b0};
                        end
                    end
                end
            endcase
        end
    end

    assign SCK_O    = sck_q;
    assign SDO_O    = sdo_q;
    assign SCK_OE_O = oe_q;
    assign SDO_OE_O = oe_q;

endmodule : icrs_streamer

`default_nettype wire

// file: icrs_streamer_monitor.sv
`default_nettype none
module icrs_streamer_monitor (
    // Clocks and reset.
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic LINK_CLK_I,
    // Watched pins.
    input wire logic CONV_DONE_I,
    input wire logic CONV_START_O,
    input wire logic SCK_O,
    input wire logic SCK_OE_O,
    input wire logic SCK_PU_O,
    input wire logic SDO_O,
    input wire logic SDO_OE_O,
    input wire logic CS_PU_O,
    input wire logic CS_SINK_O,
    input wire logic MODE_EXT_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] rise_q;
    logic       sck_q;
    logic       oe_q;
    // Counts clock rises in a frame; the edge that raises the enable is not a rise.
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rise_q <= 6'h00;
            sck_q  <= 1'b0;
            oe_q   <= 1'b0;
        end else begin
            sck_q <= SCK_O;
            oe_q  <= SCK_OE_O;
            if (!SCK_OE_O || (sck_q && !SCK_O && rise_q == 6'h20)) rise_q <= 6'h00;
            else if (oe_q && SCK_O && !sck_q) rise_q <= rise_q + 6'h01;
        end
    end
    wire rise = oe_q && SCK_O && !sck_q;
    wire done_fall = oe_q && SCK_OE_O && sck_q && !SCK_O && (rise_q == 6'h00 || rise_q == 6'h20);
    property p_frame_len; @(posedge LINK_CLK_I) disable iff (!RST_N_I) rise_q <= 6'h20; endproperty
    a_frame_len: assert property (p_frame_len) else $error("too many clock rises");
    property p_first_flag; @(posedge LINK_CLK_I) disable iff (!RST_N_I)
        rise && rise_q == 6'h00 |-> !SDO_O; endproperty
    a_first_flag: assert property (p_first_flag) else $error("first bit not low");
    property p_sdo_edge; @(posedge LINK_CLK_I) disable iff (!RST_N_I)
        oe_q && SCK_OE_O && $changed(SDO_O) |-> $fell(SCK_O) || (SDO_O && SCK_O); endproperty
    a_sdo_edge: assert property (p_sdo_edge) else $error("data moved off a fall");
    property p_end_high; @(posedge LINK_CLK_I) disable iff (!RST_N_I)
        rise && rise_q == 6'h1F |=> SCK_O && SDO_O; endproperty
    a_end_high: assert property (p_end_high) else $error("pins not high after frame");
    property p_sleep_min; @(posedge LINK_CLK_I) disable iff (!RST_N_I)
        done_fall |-> !SDO_O ##1 (!SCK_O && !SDO_O); endproperty
    a_sleep_min: assert property (p_sleep_min) else $error("sleep too short");
    property p_sink; @(posedge CLK_I) disable iff (!RST_N_I)
        CONV_DONE_I && CS_PU_O |-> ##2 (CS_SINK_O && !CS_PU_O && SCK_PU_O); endproperty
    a_sink: assert property (p_sink) else $error("no discharge after completion");
    property p_restart; @(posedge CLK_I) disable iff (!RST_N_I)
        CONV_START_O |=> !CONV_START_O && CS_PU_O && !CS_SINK_O; endproperty
    a_restart: assert property (p_restart) else $error("select not pulled up");
    property p_release; @(posedge CLK_I) disable iff (!RST_N_I)
        SDO_OE_O == SCK_OE_O && !(MODE_EXT_O && SCK_OE_O); endproperty
    a_release: assert property (p_release) else $error("pin enables wrong");
    c_frame: cover property (@(posedge LINK_CLK_I) rise && rise_q == 6'h1F);
    c_ext: cover property (@(posedge CLK_I) MODE_EXT_O);
    c_sleep: cover property (@(posedge CLK_I) CS_SINK_O);
endmodule // icrs_streamer_monitor
bind icrs_streamer icrs_streamer_monitor icrs_streamer_monitor_inst (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .LINK_CLK_I(LINK_CLK_I), .CONV_DONE_I(CONV_DONE_I),
    .CONV_START_O(CONV_START_O), .SCK_O(SCK_O), .SCK_OE_O(SCK_OE_O), .SCK_PU_O(SCK_PU_O),
    .SDO_O(SDO_O), .SDO_OE_O(SDO_OE_O), .CS_PU_O(CS_PU_O), .CS_SINK_O(CS_SINK_O),
    .MODE_EXT_O(MODE_EXT_O));
`default_nettype wire

// file: icrs_ctrl_model.sv
`default_nettype none
module icrs_ctrl_model (
    // Device pins and the outside pull-down on the clock.
    input  wire logic        rst_n_i,
    input  wire logic        sck_i,
    input  wire logic        sck_oe_i,
    input  wire logic        sck_pu_i,
    input  wire logic        sdo_i,
    input  wire logic        sdo_oe_i,
    input  wire logic        hold_low_i,
    // Resolved clock pin and received frames.
    output logic             sck_pin_o,
    output logic [31:0]      word_o,
    output logic [7:0]       frames_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] shift_q;
    logic [5:0]  bits_q;
    logic        sdo_pin;
    // A released pin with neither pull-up nor pull-down flips, so a stale level can never pass as data.
    assign sck_pin_o = sck_oe_i ? sck_i : (hold_low_i ? 1'b0 : (sck_pu_i ? 1'b1 : ~sck_i));
    assign sdo_pin   = sdo_oe_i ? sdo_i : ~sdo_i;
    // Data is taken on every rise of the pin while the clock is driven, the flag first.
    always @(posedge sck_pin_o or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bits_q   <= 6'h00;
            frames_o <= 8'h00;
        end else if (sck_oe_i) begin
            shift_q <= {shift_q[30:0], sdo_pin};
            bits_q  <= (bits_q == 6'h1F) ? 6'h00 : bits_q + 6'h01;
            if (bits_q == 6'h1F) begin
                word_o   <= {shift_q[30:0], sdo_pin};
                frames_o <= frames_o + 8'h01;
            end
        end
    end
endmodule // icrs_ctrl_model
`default_nettype wire

// file: tb_internal_clock_result_streamer.sv
`default_nettype none
module tb_internal_clock_result_streamer;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned POR_SIM = 20;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic conv_done = 1'b0;
    logic cs_low = 1'b1;
    logic hold_low = 1'b0;
    logic [icrs_pkg::RES_W-1:0] result = 31'h00000000;
    logic conv_start, sck_o, sck_oe, sck_pu, sdo_o, sdo_oe, cs_pu, cs_sink, mode_ext, sck_pin;
    logic [31:0] word;
    logic [7:0]  frames;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    // Core clock, and a link clock offset so its edges never meet the core's.
    always #2.5 clk = ~clk;
    initial begin
        #1.3;
        forever #24 link_clk = ~link_clk;
    end
    icrs_streamer #(.POR_CYCLES(POR_SIM)) icrs_streamer_inst (
        .CLK_I(clk), .RST_N_I(rst_n), .LINK_CLK_I(link_clk), .CONV_DONE_I(conv_done),
        .RESULT_I(result), .CONV_START_O(conv_start), .SCK_I(sck_pin), .SCK_O(sck_o),
        .SCK_OE_O(sck_oe), .SCK_PU_O(sck_pu), .SDO_O(sdo_o), .SDO_OE_O(sdo_oe),
        .CS_LOW_I(cs_low), .CS_PU_O(cs_pu), .CS_SINK_O(cs_sink), .MODE_EXT_O(mode_ext));
    icrs_ctrl_model icrs_ctrl_model_inst (
        .rst_n_i(rst_n), .sck_i(sck_o), .sck_oe_i(sck_oe), .sck_pu_i(sck_pu), .sdo_i(sdo_o),
        .sdo_oe_i(sdo_oe), .hold_low_i(hold_low), .sck_pin_o(sck_pin), .word_o(word),
        .frames_o(frames));
    task automatic finish_test();
        if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // A hang counts as a mismatch and closes the run.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic do_reset(input logic ext);
        hold_low = ext;
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        check("reset pins", 32'h40,
              32'({sck_pu, sck_oe, sdo_oe, cs_pu, cs_sink, conv_start, mode_ext}));
        rst_n = 1'b1;
    endtask
    // Waits for a start, checks the converting pins, then reports completion.
    task automatic convert(input logic [30:0] v);
        int i;
        for (i = 0; i < 2000 && conv_start !== 1'b1; i++) @(negedge clk);
        check("start", 32'h1, 32'(conv_start));
        repeat (40) @(negedge clk);
        check("converting pins", 32'hF, 32'({sck_oe, sck_o, sdo_o, cs_pu}));
        result = v;
        conv_done = 1'b1;
        @(negedge clk);
        conv_done = 1'b0;
    endtask
    task automatic get_frame(input logic [30:0] v);
        logic [7:0] f0;
        int i;
        f0 = frames;
        for (i = 0; i < 3000 && frames === f0; i++) @(negedge clk);
        check("frame count", 32'(f0 + 8'h01), 32'(frames));
        check("frame", {1'b0, v}, word);
    endtask
    // Select tied low; a stray completion in sleep must not alter the sent result.
    task automatic t_continuous(input logic [30:0] v);
        cs_low = 1'b1;
        convert(v);
        repeat (2) @(negedge clk);
        result = ~v;
        conv_done = 1'b1;
        @(negedge clk);
        conv_done = 1'b0;
        get_frame(v);
    endtask
    // Sleep lasts until the select comparator trips, then one frame and a restart.
    task automatic t_autostart(input logic [30:0] v);
        logic [7:0] f0;
        cs_low = 1'b0;
        convert(v);
        f0 = frames;
        repeat (200) @(negedge clk);
        check("sleep hold", {21'h000000, f0, 3'h6},
              32'({frames, cs_sink, sck_pu, mode_ext}));
        cs_low = 1'b1;
        get_frame(v);
        cs_low = 1'b0;
        convert(~v);
    endtask
    // Clock held low through power-on reset selects external mode, pins released.
    task automatic t_external();
        do_reset(1'b1);
        repeat (POR_SIM + 10) @(negedge clk);
        check("ext mode", 32'h2, 32'({mode_ext, sck_oe}));
    endtask
    initial begin
        t_external();
        do_reset(1'b0);
        t_continuous(31'h7FFFFFFF);
        t_continuous(31'h00000000);
        t_continuous(31'h2AAAAAAA);
        t_autostart(31'h15555555);
        finish_test();
    end
endmodule // tb_internal_clock_result_streamer
`default_nettype wire
